//--- design/oaseq_top.sv
// Purpose: Slot sequencer, sample and burst timing, averaging, Wishbone registers
// Assumes: Converter data valid at the end of each integration window
// Notes:   Results leave as a valid/ready stream toward the output FIFO
//
// Decided for this implementation: register access over Wishbone and the register offsets.
module oaseq_top
  import oaseq_pkg::*;
#(
  parameter int SAMPLE_BASE_CYC = CLK_HZ / SAMPLE_MIN_SPS,
  parameter int BURST_CYC_0     = CLK_HZ / BURST_HZ[0],
  parameter int BURST_CYC_1     = CLK_HZ / BURST_HZ[1],
  parameter int BURST_CYC_2     = CLK_HZ / BURST_HZ[2],
  parameter int BURST_CYC_3     = CLK_HZ / BURST_HZ[3],
  parameter int TINT_LONG_CYC   = ns_to_cyc(TINT_NS[3]),
  parameter int DUAL_GAP_CYC    = MAINS_HALF_NS / 1000 * CLK_MHZ
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  input  wire logic             we_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output logic                  ack_o,
  input  wire logic             accel_trig_i,
  input  wire logic [ADC_W-1:0] photodiode_channel_one_i,
  input  wire logic [ADC_W-1:0] photodiode_channel_two_i,
  output logic      [2:0]       emitter_en_o,
  output logic                  integrate_o,
  output logic      [23:0]      led_code_o,
  output logic      [5:0]       led_range_o,
  output logic      [3:0]       pd_range_o,
  output oaseq_res_s            res_o,
  output logic                  res_valid_o,
  input  wire logic             res_ready_i
);

  localparam logic [2:0] LAST_SLOT = 3'(NSLOT - 1);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  oaseq_ctrl_s  ctrl, next_ctrl;
  oaseq_conv_s  conv, next_conv;
  logic [23:0]  slots, next_slots;
  logic [23:0]  lcur, next_lcur;
  logic [5:0]   lrng, next_lrng;
  logic         ack, next_ack;
  logic [31:0]  rdat, next_rdat;
  logic [31:0]  rv, wv;
  logic         burst_slow;
  oaseq_state_e state, next_state;
  logic [2:0]   slot, next_slot;
  logic [7:0]   inst, next_inst;

  always_comb begin
    if (adr_i == A_CTRL) begin
      rv = 32'(ctrl);
    end else if (adr_i == A_CONV) begin
      rv = 32'(conv);
    end else if (adr_i == A_SLOT) begin
      rv = {8'h00, slots};
    end else if (adr_i == A_LCUR) begin
      rv = {8'h00, lcur};
    end else if (adr_i == A_LRNG) begin
      rv = {26'h0000000, lrng};
    end else if (adr_i == A_STAT) begin
      rv = {8'h00, inst, 5'h00, slot, 3'h0, state};
    end else begin
      rv = 32'h00000000;
    end
    for (int b = 0; b < 4; b++) begin
      wv[8*b +: 8] = sel_i[b] ? dat_i[8*b +: 8] : rv[8*b +: 8];
    end
  end

  always_comb begin
    next_ack   = cyc_i & stb_i & ~ack;
    next_rdat  = rdat;
    next_ctrl  = ctrl;
    next_conv  = conv;
    next_slots = slots;
    next_lcur  = lcur;
    next_lrng  = lrng;
    if (cyc_i & stb_i & ~ack) begin
      next_rdat = rv;
    end
    if (cyc_i & stb_i & we_i & ack) begin
      if (adr_i == A_CTRL) begin
        next_ctrl = wv[9:0];
      end else if (adr_i == A_CONV) begin
        next_conv = wv[13:0];
      end else if (adr_i == A_SLOT) begin
        next_slots = wv[23:0];
      end else if (adr_i == A_LCUR) begin
        next_lcur = wv[23:0];
      end else if (adr_i == A_LRNG) begin
        next_lrng = wv[5:0];
      end
    end
    // Hardware clear wins over a same-cycle write; rechecked every cycle
    if (burst_slow) begin
      next_ctrl.burst_en = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      rdat  <= 32'h00000000;
      ctrl  <= CTRL_RST;
      conv  <= CONV_RST;
      slots <= SLOT_RST;
      lcur  <= LCUR_RST;
      lrng  <= LRNG_RST;
    end else begin
      ack   <= next_ack;
      rdat  <= next_rdat;
      ctrl  <= next_ctrl;
      conv  <= next_conv;
      slots <= next_slots;
      lcur  <= next_lcur;
      lrng  <= next_lrng;
    end
  end

  assign ack_o       = ack;
  assign dat_o       = rdat;
  assign led_code_o  = lcur;
  assign led_range_o = lrng;
  assign pd_range_o  = {conv.range_two, conv.range_one};

  // ---------------------------------------------------------------
  // Sample, burst and trigger timing
  // ---------------------------------------------------------------
  logic [31:0] tcnt, next_tcnt, bcnt, next_bcnt, period_cyc, burst_cyc;
  logic [39:0] span;
  logic [3:0]  rate_idx, sh;
  logic        dual, tick, btick, armed, next_armed;
  logic        trig_m, trig_s, trig_d, trig_edge;
  logic [3:0]  code;
  logic [31:0] settle_cyc, tint_cyc;

  always_comb begin
    rate_idx   = (conv.sample_rate_select[3:0] > 4'(RATE_MAX_IDX)) ? 4'(RATE_MAX_IDX)
                                                                   : conv.sample_rate_select[3:0];
    dual       = conv.sample_rate_select[4];
    period_cyc = 32'(SAMPLE_BASE_CYC) >> rate_idx;
    case (ctrl.burst_rate)
      2'h0:    burst_cyc = 32'(BURST_CYC_0);
      2'h1:    burst_cyc = 32'(BURST_CYC_1);
      2'h2:    burst_cyc = 32'(BURST_CYC_2);
      default: burst_cyc = 32'(BURST_CYC_3);
    endcase
    // Burst needs at least two conversions; a count of one moves up to two
    sh = (ctrl.burst_en && conv.average_count_select == 3'h0) ? 4'h1 : 4'(conv.average_count_select);
    sh = sh + 4'(dual);
    span       = 40'(period_cyc) << sh;
    burst_slow = ctrl.burst_en && (span > 40'(burst_cyc));
    next_tcnt  = (tcnt >= period_cyc - 32'h1) ? 32'h0 : tcnt + 32'h1;
    next_bcnt  = (bcnt >= burst_cyc - 32'h1) ? 32'h0 : bcnt + 32'h1;
    trig_edge  = trig_s & ~trig_d;
    if (ctrl.gpio_ctrl == GPIO_TRIG) begin
      tick = trig_edge;
    end else begin
      // Second pulse half a mains cycle later, so line flicker averages out
      tick = (tcnt == 32'h0) ||
             (dual && DUAL_GAP_CYC < int'(period_cyc) && tcnt == 32'(DUAL_GAP_CYC));
    end
    btick      = (bcnt == 32'h0);
    // Burst tick arms a burst; a tick wins over the drain-start clear
    next_armed = ctrl.burst_en ? ((armed && next_state != ST_DRAIN) || btick) : 1'b1;
    settle_cyc = 32'(ns_to_cyc(SETTLE_NS[ctrl.settle]));
    tint_cyc   = (conv.tint == 2'h3) ? 32'(TINT_LONG_CYC) : 32'(ns_to_cyc(TINT_NS[conv.tint]));
    code       = slots[4*slot +: 4];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcnt   <= 32'h0;
      bcnt   <= 32'h0;
      armed  <= 1'b0;
      trig_m <= 1'b0;
      trig_s <= 1'b0;
      trig_d <= 1'b0;
    end else begin
      tcnt   <= next_tcnt;
      bcnt   <= next_bcnt;
      armed  <= next_armed;
      trig_m <= accel_trig_i;
      trig_s <= trig_m;
      trig_d <= trig_s;
    end
  end

  // ---------------------------------------------------------------
  // Slot sequencer and averaging
  // ---------------------------------------------------------------
  logic [31:0]          tmr, next_tmr;
  logic                 mem_we;
  logic [2*ACC_W-1:0]   mem_wd, mem_rd;
  logic [ACC_W-1:0]     mean1, mean2;
  logic [8:0]           n_inst;
  oaseq_res_s           res, next_res;
  logic                 rvalid, next_rvalid;

  oaseq_acc_mem #(
    .W (2*ACC_W),
    .D (NSLOT)
  ) u_mem (
    .clk_i   (clk_i),
    .addr_i  (slot),
    .we_i    (mem_we),
    .wdata_i (mem_wd),
    .rdata_o (mem_rd)
  );

  always_comb begin
    next_state  = state;
    next_slot   = slot;
    next_inst   = inst;
    next_tmr    = tmr;
    next_res    = res;
    next_rvalid = rvalid;
    mem_we      = 1'b0;
    n_inst      = 9'h001 << sh;
    // First instance overwrites, later ones add: both channels at once
    mem_wd      = (inst == 8'h00) ?
                  {ACC_W'(photodiode_channel_one_i), ACC_W'(photodiode_channel_two_i)} :
                  {mem_rd[2*ACC_W-1:ACC_W] + ACC_W'(photodiode_channel_one_i),
                   mem_rd[ACC_W-1:0] + ACC_W'(photodiode_channel_two_i)};
    mean1       = mem_rd[2*ACC_W-1:ACC_W] >> sh;
    mean2       = mem_rd[ACC_W-1:0] >> sh;
    case (state)
      ST_IDLE: begin
        if (ctrl.run && armed && tick) begin
          next_state = ST_SETTLE;
          next_slot  = 3'h0;
          next_tmr   = 32'h0;
        end
      end
      ST_SETTLE: begin
        next_tmr = tmr + 32'h1;
        if (em_skip(code)) begin
          next_state = ST_ADV;
        end else if (tmr >= settle_cyc - 32'h1) begin
          next_state = ST_INTEG;
          next_tmr   = 32'h0;
        end
      end
      ST_INTEG: begin
        next_tmr = tmr + 32'h1;
        if (tmr >= tint_cyc - 32'h1) begin
          mem_we     = 1'b1;
          next_state = ST_ADV;
        end
      end
      ST_ADV: begin
        next_tmr = 32'h0;
        if (slot != LAST_SLOT) begin
          next_slot  = slot + 3'h1;
          next_state = ST_SETTLE;
        end else if (9'(inst) >= n_inst - 9'h001) begin
          next_slot  = 3'h0;
          next_inst  = 8'h00;
          next_state = ST_DRAIN;
        end else begin
          next_inst  = inst + 8'h01;
          next_state = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        if (rvalid) begin
          if (res_ready_i) begin
            next_rvalid = 1'b0;
            next_tmr    = 32'h0;
            next_slot   = (slot == LAST_SLOT) ? 3'h0 : slot + 3'h1;
            next_state  = (slot == LAST_SLOT) ? ST_IDLE : ST_DRAIN;
          end
        end else if (tmr == 32'h0) begin
          next_tmr = 32'h1; // Read data lags slot by a cycle
        end else if (em_skip(slots[4*slot +: 4])) begin
          next_tmr   = 32'h0;
          next_slot  = (slot == LAST_SLOT) ? 3'h0 : slot + 3'h1;
          next_state = (slot == LAST_SLOT) ? ST_IDLE : ST_DRAIN;
        end else begin
          next_res    = '{slot: slot, chan_one: mean1[ADC_W-1:0], chan_two: mean2[ADC_W-1:0]};
          next_rvalid = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= ST_IDLE;
      slot   <= 3'h0;
      inst   <= 8'h00;
      tmr    <= 32'h0;
      res    <= '0;
      rvalid <= 1'b0;
    end else begin
      state  <= next_state;
      slot   <= next_slot;
      inst   <= next_inst;
      tmr    <= next_tmr;
      res    <= next_res;
      rvalid <= next_rvalid;
    end
  end

  assign emitter_en_o = (state == ST_SETTLE || state == ST_INTEG) ? em_mask(code) : 3'h0;
  assign integrate_o  = (state == ST_INTEG);
  assign res_o        = res;
  assign res_valid_o  = rvalid;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [31:0] hlen;

  always_ff @(posedge clk_i) begin
    if (rst_i || next_state != state) begin
      hlen <= 32'h0;
    end else begin
      hlen <= hlen + 32'h1;
    end
  end

  property p_skip;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_SETTLE && em_skip(code)) |-> emitter_en_o == 3'h0 ##1 state == ST_ADV;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped slot lit an emitter");

  property p_emit;
    @(posedge clk_i) disable iff (rst_i)
      integrate_o |-> emitter_en_o == em_mask(slots[4*slot +: 4]);
  endproperty
  a_emit: assert property (p_emit) else $error("emitter mask differs from slot code");

  property p_settle;
    @(posedge clk_i) disable iff (rst_i)
      $rose(integrate_o) |-> $past(state) == ST_SETTLE && $past(hlen) == settle_cyc - 32'h1
                             && $stable(emitter_en_o);
  endproperty
  a_settle: assert property (p_settle) else $error("settling interval wrong");

  property p_tint;
    @(posedge clk_i) disable iff (rst_i)
      $fell(integrate_o) |-> $past(hlen) == tint_cyc - 32'h1 && state == ST_ADV;
  endproperty
  a_tint: assert property (p_tint) else $error("integration window wrong");

  property p_order;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_ADV && slot != LAST_SLOT) |=> state == ST_SETTLE && slot == $past(slot) + 3'h1;
  endproperty
  a_order: assert property (p_order) else $error("slot order broken");

  property p_burst_clr;
    @(posedge clk_i) disable iff (rst_i)
      burst_slow |=> !ctrl.burst_en;
  endproperty
  a_burst_clr: assert property (p_burst_clr) else $error("burst enable not cleared");

  property p_trig;
    @(posedge clk_i) disable iff (rst_i)
      (state == ST_IDLE && ctrl.gpio_ctrl == GPIO_TRIG && !trig_edge) |=> state == ST_IDLE;
  endproperty
  a_trig: assert property (p_trig) else $error("instance started without trigger");

  property p_res_hold;
    @(posedge clk_i) disable iff (rst_i)
      (res_valid_o && !res_ready_i) |=> res_valid_o && $stable(res_o);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result dropped before taken");

  property p_cont;
    @(posedge clk_i) disable iff (rst_i)
      (!rst_i && !ctrl.burst_en) |=> armed;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode not armed");

  c_push:  cover property (@(posedge clk_i) disable iff (rst_i) res_valid_o && res_ready_i);
  c_clear: cover property (@(posedge clk_i) disable iff (rst_i) $fell(ctrl.burst_en));
  c_trig:  cover property (@(posedge clk_i) disable iff (rst_i) state == ST_IDLE ##1 state == ST_SETTLE);

endmodule

//--- shared/oaseq_pkg.sv
// Purpose: Constants, types and helpers for the optical acquisition sequencer
// Assumes: 40 MHz system clock, classic Wishbone register access
// Notes:   Long cycle counts are overridable as top-level parameters
//
// Function
// - With burst off, one conversion set runs every sample period at the selected rate.
// - With burst on, a burst of conversions runs at the sample rate and its average is pushed out.
// - Burst repetition rate is selectable as 8, 32, 84 or 256 Hz.
// - A burst count of one is not supported in burst mode and is replaced by a count of two.
// - If the sample rate is too slow for the burst rate, hardware clears burst enable and runs continuously.
// - Integration window is selectable as 14.8, 29.4, 58.7 or 117.3 us.
// - Each photodiode channel has a two-bit full-scale range select (4, 8, 16, 32 uA).
// - Between 1 and 128 consecutive samples may be averaged before a result is presented.
// - Each slot lights emitter 1, 2 or 3, any pair, all three, none for ambient, or is skipped.
// - Slots run strictly one to six, each to its own result field, repeated every sample instance.
// - Each emitter driver has a four-way range select and an 8-bit current code.
// - The emitter is switched on a settling time of 12, 8, 6 or 4 us before integration starts.
// - With pin control set to 2, each sample instance is started by the external accelerometer trigger.
// - Both photodiode channels are converted together in every programmed slot.
// - Sample rate spans 8 to 4096 samples per second.
// - Dual-pulse modes space two exposures unevenly within each period longer than half a mains cycle and average them.
package oaseq_pkg;

  // ---------------------------------------------------------------
  // Clock and sizes
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int CLK_MHZ        = 40;
  localparam int ADC_W          = 20;
  localparam int NSLOT          = 6;
  localparam int ACC_W          = ADC_W + 8;
  localparam int SAMPLE_MIN_SPS = 8;
  localparam int RATE_MAX_IDX   = 9;
  localparam int MAINS_HALF_NS  = 10_000_000;
  localparam int SETTLE_NS [4]  = '{12000, 8000, 6000, 4000};
  localparam int TINT_NS   [4]  = '{14800, 29400, 58700, 117300};
  localparam int BURST_HZ  [4]  = '{8, 32, 84, 256};

  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  A_CTRL    = 8'h00;
  localparam logic [7:0]  A_CONV    = 8'h04;
  localparam logic [7:0]  A_SLOT    = 8'h08;
  localparam logic [7:0]  A_LCUR    = 8'h0c;
  localparam logic [7:0]  A_LRNG    = 8'h10;
  localparam logic [7:0]  A_STAT    = 8'h14;
  localparam logic [9:0]  CTRL_RST  = 10'h000;
  localparam logic [13:0] CONV_RST  = 14'h0000;
  localparam logic [23:0] SLOT_RST  = 24'h000000;
  localparam logic [23:0] LCUR_RST  = 24'h000000;
  localparam logic [5:0]  LRNG_RST  = 6'h00;
  localparam logic [3:0]  GPIO_TRIG = 4'h2;

  typedef struct packed {
    logic [3:0] gpio_ctrl;
    logic [1:0] settle;
    logic [1:0] burst_rate;
    logic       burst_en;
    logic       run;
  } oaseq_ctrl_s;

  typedef struct packed {
    logic [4:0] sample_rate_select;
    logic [2:0] average_count_select;
    logic [1:0] range_two;
    logic [1:0] range_one;
    logic [1:0] tint;
  } oaseq_conv_s;

  typedef struct packed {
    logic [2:0]       slot;
    logic [ADC_W-1:0] chan_one;
    logic [ADC_W-1:0] chan_two;
  } oaseq_res_s;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETTLE = 5'b00010,
    ST_INTEG  = 5'b00100,
    ST_ADV    = 5'b01000,
    ST_DRAIN  = 5'b10000
  } oaseq_state_e;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic int ns_to_cyc(input int ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction

  // Slot code to emitter mask; 8 is ambient, 0 and 9..15 skip the slot
  function automatic logic [2:0] em_mask(input logic [3:0] code);
    case (code)
      4'h1:    return 3'h1;
      4'h2:    return 3'h2;
      4'h3:    return 3'h4;
      4'h4:    return 3'h3;
      4'h5:    return 3'h5;
      4'h6:    return 3'h6;
      4'h7:    return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic em_skip(input logic [3:0] code);
    return (code == 4'h0) || (code > 4'h8);
  endfunction

endpackage

//--- design/oaseq_acc_mem.sv
// Purpose: Per-slot accumulator store, one word holds both channels
// Assumes: Single clock, one write port, registered read
// Notes:   Read data lags the address by one cycle
module oaseq_acc_mem #(
  parameter int W = 56,
  parameter int D = 6
) (
  input  wire logic                 clk_i,
  input  wire logic [$clog2(D)-1:0] addr_i,
  input  wire logic                 we_i,
  input  wire logic [W-1:0]         wdata_i,
  output logic      [W-1:0]         rdata_o
);

  logic [W-1:0] mem [D];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

//--- sim/oaseq_far_model.sv
// Purpose: Converter and result-sink stand-in at the sequencer's far side
// Assumes: Same clock as the sequencer
// Notes:   Sink stalls three cycles on every word
module oaseq_far_model
  import oaseq_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [2:0]       emitter_en_i,
  input  wire logic             integrate_i,
  input  wire logic             res_valid_i,
  output logic                  res_ready_o,
  output logic      [ADC_W-1:0] chan_one_o,
  output logic      [ADC_W-1:0] chan_two_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] stall;
  // Inverted outside the window, so an early or late sample shows
  assign chan_one_o = integrate_i ? {17'h00080, emitter_en_i} : ~{17'h00080, emitter_en_i};
  assign chan_two_o = integrate_i ? {17'h00100, emitter_en_i} : ~{17'h00100, emitter_en_i};
  always_ff @(posedge clk_i) begin
    if (rst_i || (res_valid_i && res_ready_o)) begin
      stall       <= 2'h0;
      res_ready_o <= 1'b0;
    end else if (res_valid_i) begin
      stall       <= stall + 2'h1;
      res_ready_o <= (stall == 2'h2);
    end
  end
endmodule

//--- sim/oaseq_top_tb_top.sv
// Purpose: Self-checking bench for the acquisition sequencer
// Assumes: Shortened sample and burst counts
// Notes:   Register rows first, sequencing cases after
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module oaseq_top_tb_top
  import oaseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e;} oaseq_row_s;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, trig = 0, ack, rdy, val, integ;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, rd, dat_o;
  logic [3:0] sel = 0, pdr;
  logic [2:0] em;
  logic [23:0] code;
  logic [5:0] lrng;
  logic [ADC_W-1:0] c1, c2;
  oaseq_res_s res, q[$];
  int miscompares = 0, comparisons = 0;
  oaseq_row_s rows [15] = '{
    '{A_CTRL, 0, 0, 32'(CTRL_RST)}, '{A_CONV, 0, 0, 32'(CONV_RST)}, '{A_SLOT, 0, 0, 32'(SLOT_RST)},
    '{A_LCUR, 0, 0, 32'(LCUR_RST)}, '{A_LRNG, 0, 0, 32'(LRNG_RST)}, '{A_STAT, 0, 0, 32'h1},
    '{8'h20, 0, 0, 0}, '{A_CTRL, 4'hf, 32'h3f8, 32'h3f8}, '{A_CONV, 4'hf, 32'h1ab5, 32'h1ab5},
    '{A_SLOT, 4'hf, 32'hffabcdef, 32'habcdef}, '{A_LCUR, 4'hf, 32'h123456, 32'h123456},
    '{A_LCUR, 4'h1, 32'hffffffff, 32'h1234ff}, '{A_LRNG, 4'hf, 32'hff, 32'h3f},
    '{8'h20, 4'hf, 32'hffffffff, 0}, '{A_STAT, 4'hf, 32'hffffffff, 32'h1}};
  always #12.5 clk_i = ~clk_i;
  oaseq_top #(.SAMPLE_BASE_CYC(4000), .BURST_CYC_0(20000), .BURST_CYC_3(2000), .TINT_LONG_CYC(200),
    .DUAL_GAP_CYC(300)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .we_i(we), .sel_i(sel),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .accel_trig_i(trig), .photodiode_channel_one_i(c1),
    .photodiode_channel_two_i(c2), .emitter_en_o(em), .integrate_o(integ), .led_code_o(code),
    .led_range_o(lrng), .pd_range_o(pdr), .res_o(res), .res_valid_o(val), .res_ready_i(rdy));
  oaseq_far_model far_u (.clk_i(clk_i), .rst_i(rst_i), .emitter_en_i(em), .integrate_i(integ),
    .res_valid_i(val), .res_ready_o(rdy), .chan_one_o(c1), .chan_two_o(c2));
  always @(posedge clk_i) if (val === 1'b1 && rdy === 1'b1) q.push_back(res);
  // ---------------------------------------------------------------
  // Bus and checking tasks
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50) miscompares++;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  endtask
  task automatic wait_q(input int n, input int lim);
    int k;
    k = 0;
    while (q.size() < n && k < lim) begin @(posedge clk_i); k++; end
    `CHK("result count", n, q.size())
  endtask
  task automatic chk_res(input int i, input logic [2:0] sl, input logic [2:0] m);
    `CHK("slot", sl, q[i].slot)
    `CHK("chan one", {17'h00080, m}, q[i].chan_one)
    `CHK("chan two", {17'h00100, m}, q[i].chan_two)
  endtask
  task automatic stop();
    wb(1, A_CTRL, 0, 4'hf);
    repeat (5000) @(posedge clk_i);
    q.delete();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(25ns * 90000);
    miscompares++;
    results();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].s != 0) wb(1, rows[i].a, rows[i].d, rows[i].s);
      wb(0, rows[i].a, 0, 4'hf);
      `CHK("register", rows[i].e, rd)
    end
    `CHK("led code", 24'h1234ff, code)
    `CHK("led range", 6'h3f, lrng)
    wb(1, A_CONV, 32'h18, 4'hf);
    `CHK("pd range", 4'h6, pdr)
    wb(1, A_SLOT, 32'hf07801, 4'hf);
    wb(1, A_CTRL, 32'h31, 4'hf);
    n = 0;
    while (em === 3'h0 && n < 9000) begin @(posedge clk_i); n++; end
    n = 0;
    while (integ !== 1'b1 && n < 1000) begin @(posedge clk_i); n++; end
    `CHK("settle cycles", 160, n)
    `CHK("emitter on", 3'h1, em)
    n = 0;
    while (integ === 1'b1 && n < 1000) begin @(posedge clk_i); n++; end
    `CHK("integrate cycles", 592, n)
    wait_q(6, 20000);
    chk_res(0, 3'h0, 3'h1);
    chk_res(1, 3'h2, 3'h0);
    chk_res(2, 3'h3, 3'h7);
    chk_res(3, 3'h0, 3'h1);
    stop();
    // Burst of two, one set per 20000-cycle tick
    wb(1, A_CONV, 32'h58, 4'hf);
    wb(1, A_CTRL, 32'h33, 4'hf);
    wait_q(3, 40000);
    chk_res(2, 3'h3, 3'h7);
    repeat (10000) @(posedge clk_i);
    `CHK("burst sets", 3, q.size())
    wb(0, A_CTRL, 0, 4'hf);
    `CHK("burst kept", 32'h33, rd)
    stop();
    // Eight samples cannot fit a 2000-cycle burst
    wb(1, A_CONV, 32'hd8, 4'hf);
    wb(1, A_CTRL, 32'h3f, 4'hf);
    repeat (10) @(posedge clk_i);
    wb(0, A_CTRL, 0, 4'hf);
    `CHK("burst cleared", 32'h3d, rd)
    stop();
    // Dual pulse, long window: two instances per averaged set
    wb(1, A_CONV, 32'h2003, 4'hf);
    wb(1, A_CTRL, 32'h31, 4'hf);
    wait_q(3, 12000);
    chk_res(2, 3'h3, 3'h7);
    stop();
    wb(1, A_CONV, 32'h18, 4'hf);
    wb(1, A_CTRL, 32'hb1, 4'hf);
    repeat (9000) @(posedge clk_i);
    `CHK("no trigger", 0, q.size())
    trig <= 1;
    repeat (4) @(posedge clk_i);
    trig <= 0;
    wait_q(3, 5000);
    chk_res(0, 3'h0, 3'h1);
    results();
  end
endmodule
